// ### ftb_ctl_model.sv
`timescale 1ns/1ps
// ****************************************
// Controller model on the far side
// ****************************************
module ftb_ctl_model (
   input wire logic clk,
   output logic [5:0] addr,
   output logic qual_n,
   output logic step,
   output logic we_n,
   output logic [3:0] lanes_n,
   output logic cs1_n,
   output logic cs2,
   output logic cs3_n,
   output logic [35:0] wd
);
   // Quiet bus at time zero with the device deselected
   initial begin
      addr = 6'h00;
      qual_n = 1'b0;
      step = 1'b0;
      we_n = 1'b1;
      lanes_n = 4'hF;
      cs1_n = 1'b1;
      cs2 = 1'b1;
      cs3_n = 1'b0;
      wd = 36'h0;
   end

   // One edge: kind 0 deselect, 1 load, 2 burst step
   task automatic drive(input logic [1:0] kind, input logic [5:0] a,
      input logic w_n, input logic [3:0] ln, input logic stl,
      input logic wr, input logic [35:0] d);
      @(posedge clk);
      qual_n <= stl;
      step <= kind == 2'h2; // Step pin high only for burst steps
      // Deselect drops one select picked by the address; steps toggle one
      cs1_n <= kind == 2'h0 && a[1:0] == 2'h0;
      cs2 <= !(kind == 2'h0 && a[1:0] == 2'h1);
      cs3_n <= (kind == 2'h0 && a[1]) || (kind == 2'h2 && a[0]);
      addr <= a;
      we_n <= w_n;
      lanes_n <= ln; // Lane pattern given again on every beat
      // Data only in its write phase; else churn, as a released bus would
      wd <= wr ? d : ~wd;
   endtask : drive
endmodule : ftb_ctl_model

// ### ftb_params.svh
`ifndef FTB_PARAMS_SVH
`define FTB_PARAMS_SVH
`define FTB_ADDR_W 19
`define FTB_LANES 4
`define FTB_LANE_W 9
`define FTB_CLK_PERIOD_PS 8000
`define FTB_CLOCK_TO_DATA_TIME_PS 6500
`define FTB_CDV_CYC ((`FTB_CLOCK_TO_DATA_TIME_PS / `FTB_CLK_PERIOD_PS) > 0 ? \
   (`FTB_CLOCK_TO_DATA_TIME_PS / `FTB_CLK_PERIOD_PS) : 1)
`define FTB_SLEEP_ENTER_CYC 2
`define FTB_SLEEP_EXIT_CYC 2
`define FTB_STEP_ONE 2'h1
`endif

// ### ftb_pkg.sv
`include "ftb_params.svh"
package ftb_pkg;
   // Operation held in the data-phase slot
   typedef enum logic [1:0] {FTB_OP_IDLE, FTB_OP_READ, FTB_OP_WRITE} ftb_op_t;
   // Sleep sequencing
   typedef enum logic [1:0] {FTB_AWAKE, FTB_ENTER, FTB_ASLEEP, FTB_EXIT}
      ftb_sleep_t;
   // Pending write beat
   typedef struct packed {
      logic valid;
      logic [`FTB_ADDR_W-1:0] addr;
      logic [`FTB_LANES-1:0] lanes_n;
   } ftb_wr_t;
endpackage : ftb_pkg

// ### ftb_sram_core.sv
`timescale 1ns/1ps
`include "ftb_params.svh"
module ftb_sram_core #(
   parameter int ADDR_W = `FTB_ADDR_W
) (
   REF_CLK,
   RESET_N,
   ADDR,
   CLOCK_QUALIFIER_N,
   BURST_STEP_OR_LOAD,
   WRITE_ENABLE_N,
   BYTE_LANE_SELECT_N,
   CHIP_SELECT_FIRST_N,
   CHIP_SELECT_SECOND,
   CHIP_SELECT_THIRD_N,
   OUTPUT_GATE_N,
   SLEEP_REQUEST,
   BURST_ORDER,
   DQ_IN,
   PARITY_PINS_IN,
   DQ_OUT,
   PARITY_PINS_OUT,
   DQ_OE,
   TEST_CLOCK,
   TEST_DATA_IN,
   TEST_MODE_SEL,
   TEST_DATA_SAMPLE,
   TEST_MODE_SAMPLE
);
   localparam int LANES = `FTB_LANES;
   localparam int LW = `FTB_LANE_W;
   localparam int DEPTH = 1 << ADDR_W;
   input wire logic REF_CLK;
   input wire logic RESET_N;
   input wire logic [ADDR_W-1:0] ADDR;
   input wire logic CLOCK_QUALIFIER_N;
   input wire logic BURST_STEP_OR_LOAD;
   input wire logic WRITE_ENABLE_N;
   input wire logic [LANES-1:0] BYTE_LANE_SELECT_N;
   input wire logic CHIP_SELECT_FIRST_N;
   input wire logic CHIP_SELECT_SECOND;
   input wire logic CHIP_SELECT_THIRD_N;
   input wire logic OUTPUT_GATE_N;
   input wire logic SLEEP_REQUEST;
   input wire logic BURST_ORDER;
   input wire logic [LANES*8-1:0] DQ_IN;
   input wire logic [LANES-1:0] PARITY_PINS_IN;
   output logic [LANES*8-1:0] DQ_OUT;
   output logic [LANES-1:0] PARITY_PINS_OUT;
   output logic DQ_OE;
   input wire logic TEST_CLOCK;
   input wire logic TEST_DATA_IN;
   input wire logic TEST_MODE_SEL;
   output logic TEST_DATA_SAMPLE;
   output logic TEST_MODE_SAMPLE;

   // Next burst low bits from start value and step count
   function automatic logic [1:0] ftb_burst_low(input logic [1:0] first,
      input logic [1:0] step, input logic interleave);
      ftb_burst_low = interleave ? (first ^ step) : 2'(first + step);
   endfunction : ftb_burst_low

   // ****************************************
   // Asynchronous pin synchronisers
   // ****************************************
   // Bits: 0 output gate, 1 sleep, 2 test clock, 3 test data, 4 test mode
   logic [4:0] async_in;
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] sync3_ff;
   logic [4:0] lvl_ff;
   logic tck_prev_ff;
   logic tdi_ff;
   logic tms_ff;
   assign async_in = {TEST_MODE_SEL, TEST_DATA_IN, TEST_CLOCK, SLEEP_REQUEST,
                      OUTPUT_GATE_N};

   // A level counts only once stages two and three agree
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         sync1_ff <= 5'h01; // Idle levels: gate closed, others low
         sync2_ff <= 5'h01;
         sync3_ff <= 5'h01;
         lvl_ff <= 5'h01; // A high sleep bit here would fake a sleep
      end else begin
         sync1_ff <= async_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         lvl_ff <= (sync2_ff & sync3_ff) | (lvl_ff & (sync2_ff | sync3_ff));
      end
   end

   logic gate_on;
   logic sleep_lvl;
   logic tck_rise;
   assign gate_on = !lvl_ff[0];
   assign sleep_lvl = lvl_ff[1];
   assign tck_rise = lvl_ff[2] && !tck_prev_ff;

   // Scan inputs taken on the settled rising test clock
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         tck_prev_ff <= 1'h0;
         tdi_ff <= 1'h0;
         tms_ff <= 1'h0;
      end else begin
         tck_prev_ff <= lvl_ff[2];
         if (tck_rise) begin
            tdi_ff <= lvl_ff[3];
            tms_ff <= lvl_ff[4];
         end
      end
   end
   assign TEST_DATA_SAMPLE = tdi_ff;
   assign TEST_MODE_SAMPLE = tms_ff;

   // ****************************************
   // Sleep sequencing
   // ****************************************
   ftb_pkg::ftb_sleep_t sleep_ff;
   ftb_pkg::ftb_sleep_t nxt_sleep;
   logic awake;
   always_comb begin
      case (sleep_ff)
         ftb_pkg::FTB_AWAKE: nxt_sleep = sleep_lvl ? ftb_pkg::FTB_ENTER :
                                                     ftb_pkg::FTB_AWAKE;
         ftb_pkg::FTB_ENTER: nxt_sleep = ftb_pkg::FTB_ASLEEP;
         ftb_pkg::FTB_ASLEEP: nxt_sleep = sleep_lvl ? ftb_pkg::FTB_ASLEEP :
                                                      ftb_pkg::FTB_EXIT;
         ftb_pkg::FTB_EXIT: nxt_sleep = ftb_pkg::FTB_AWAKE;
         default: nxt_sleep = ftb_pkg::FTB_AWAKE;
      endcase
   end
   assign awake = (sleep_ff == ftb_pkg::FTB_AWAKE) && !sleep_lvl;
   // Sleep steps on every edge; the qualifier does not gate it
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         sleep_ff <= ftb_pkg::FTB_AWAKE;
      end else begin
         sleep_ff <= nxt_sleep;
      end
   end

   // ****************************************
   // Command decode and burst counter
   // ****************************************
   logic order_ff;
   logic adv;
   logic cs_on;
   logic start;
   logic desel;
   logic step;
   ftb_pkg::ftb_op_t op_ff;
   ftb_pkg::ftb_op_t nxt_op;
   logic [ADDR_W-1:0] base_ff;
   logic [1:0] step_ff;
   logic [1:0] nxt_step;
   logic [ADDR_W-1:0] cur_addr;
   assign adv = !CLOCK_QUALIFIER_N && awake;
   assign cs_on = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND &&
                  !CHIP_SELECT_THIRD_N;
   assign start = !BURST_STEP_OR_LOAD && cs_on;
   assign desel = !BURST_STEP_OR_LOAD && !cs_on;
   assign step = BURST_STEP_OR_LOAD;
   // Write enable only matters at load time
   assign nxt_op = start ? (WRITE_ENABLE_N ? ftb_pkg::FTB_OP_READ :
                            ftb_pkg::FTB_OP_WRITE) :
                   desel ? ftb_pkg::FTB_OP_IDLE : op_ff;
   assign nxt_step = start ? 2'h0 :
                     2'(step_ff + `FTB_STEP_ONE);
   // Only the low two bits move; upper bits stay at the loaded value
   assign cur_addr = start ? ADDR : {base_ff[ADDR_W-1:2],
      ftb_burst_low(base_ff[1:0], nxt_step, order_ff)};

   // Strap is caught while reset is held, then frozen
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         order_ff <= BURST_ORDER;
      end
   end

   // Operation slot and counter; cleared once sleep_ff leaves FTB_AWAKE, else a stalled edge changes nothing
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N || !awake && sleep_ff != ftb_pkg::FTB_AWAKE) begin
         op_ff <= ftb_pkg::FTB_OP_IDLE;
         base_ff <= '0;
         step_ff <= 2'h0;
      end else if (adv) begin
         op_ff <= nxt_op;
         step_ff <= (start || step) ? nxt_step : step_ff;
         if (start) begin
            base_ff <= ADDR;
         end
      end
   end

   // ****************************************
   // Memory, write merge and read bypass
   // ****************************************
   logic [LANES-1:0][LW-1:0] mem [DEPTH];
   ftb_pkg::ftb_wr_t wr_ff;
   logic commit;
   logic [LANES-1:0][LW-1:0] old_word;
   logic [LANES-1:0][LW-1:0] merged;
   logic [LANES-1:0][LW-1:0] rd_word;
   assign commit = adv && wr_ff.valid;
   assign old_word = mem[wr_ff.addr[ADDR_W-1:0]];
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         // Lane keeps its old value unless its select is low
         assign merged[gi] = wr_ff.lanes_n[gi] ? old_word[gi] :
            {PARITY_PINS_IN[gi], DQ_IN[gi*8 +: 8]};
      end
   endgenerate
   // Same-edge read of the word being written sees the new data
   assign rd_word = (commit && wr_ff.addr[ADDR_W-1:0] == cur_addr) ? merged :
                    mem[cur_addr];

   // No reset on the array: contents survive sleep and reset alike
   always_ff @(posedge REF_CLK) begin
      if (RESET_N && commit) begin
         mem[wr_ff.addr[ADDR_W-1:0]] <= merged;
      end
   end

   // Pending write beat; dropped when sleep begins
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N || sleep_ff != ftb_pkg::FTB_AWAKE || sleep_lvl) begin
         wr_ff <= '0;
      end else if (adv) begin
         wr_ff.valid <= (nxt_op == ftb_pkg::FTB_OP_WRITE) &&
                        (start || step);
         wr_ff.addr <= `FTB_ADDR_W'(cur_addr);
         wr_ff.lanes_n <= BYTE_LANE_SELECT_N;
      end
   end

   // ****************************************
   // Data phase outputs
   // ****************************************
   logic rd_phase_ff;
   logic first_ff;
   logic [LANES-1:0][LW-1:0] dq_ff;
   logic oe_ff;
   logic nxt_rd_phase;
   logic nxt_first;
   assign nxt_rd_phase = adv ? (nxt_op == ftb_pkg::FTB_OP_READ) :
                         (rd_phase_ff && awake);
   assign nxt_first = adv ? (op_ff == ftb_pkg::FTB_OP_IDLE) : first_ff;

   // Driver enable follows the gate every cycle, stalled or not, but only in read phases other than the first clock after deselect
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         rd_phase_ff <= 1'h0;
         first_ff <= 1'h1;
         oe_ff <= 1'h0;
         dq_ff <= '0;
      end else begin
         rd_phase_ff <= nxt_rd_phase;
         first_ff <= nxt_first;
         oe_ff <= nxt_rd_phase && !nxt_first && gate_on;
         if (adv && nxt_op == ftb_pkg::FTB_OP_READ) begin
            dq_ff <= rd_word;
         end
      end
   end
   assign DQ_OE = oe_ff;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_out
         assign DQ_OUT[gi*8 +: 8] = dq_ff[gi][7:0];
         assign PARITY_PINS_OUT[gi] = dq_ff[gi][8];
      end
   endgenerate

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_read_start;
      adv && start && WRITE_ENABLE_N && op_ff != ftb_pkg::FTB_OP_IDLE;
   endsequence
   sequence s_sleep_go;
      sleep_ff == ftb_pkg::FTB_AWAKE && sleep_lvl;
   endsequence

   property p_stall_hold;
      CLOCK_QUALIFIER_N |=> $stable(op_ff) && $stable(step_ff) &&
                            $stable(wr_ff);
   endproperty
   a_stall_hold: assert property (p_stall_hold)
      else $error("state moved on a stalled edge");
   property p_read_out;
      s_read_start ##0 gate_on ##1 gate_on |-> DQ_OE &&
         dq_ff == $past(rd_word);
   endproperty
   a_read_out: assert property (p_read_out)
      else $error("read data not driven after read start");
   property p_desel_off;
      adv && desel |=> !DQ_OE;
   endproperty
   a_desel_off: assert property (p_desel_off)
      else $error("drivers on after deselect");
   property p_write_off;
      adv && start && !WRITE_ENABLE_N |=> !DQ_OE && wr_ff.valid;
   endproperty
   a_write_off: assert property (p_write_off)
      else $error("write start left drivers on or no pending beat");
   property p_first_off;
      adv && op_ff == ftb_pkg::FTB_OP_IDLE |=> !DQ_OE;
   endproperty
   a_first_off: assert property (p_first_off)
      else $error("drivers on in first clock after deselect");
   property p_step_wrap;
      adv && step |=> step_ff == 2'($past(step_ff) + `FTB_STEP_ONE);
   endproperty
   a_step_wrap: assert property (p_step_wrap)
      else $error("burst step did not advance modulo four");
   property p_type_kept;
      adv && step |=> op_ff == $past(op_ff);
   endproperty
   a_type_kept: assert property (p_type_kept)
      else $error("operation type changed during burst");
   property p_sleep_enter;
      s_sleep_go |=> sleep_ff == ftb_pkg::FTB_ENTER ##1
                     sleep_ff == ftb_pkg::FTB_ASLEEP;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter)
      else $error("sleep entry not two cycles");
   property p_sleep_drop;
      s_sleep_go |=> !wr_ff.valid && !DQ_OE;
   endproperty
   a_sleep_drop: assert property (p_sleep_drop)
      else $error("pending access survived sleep entry");
endmodule : ftb_sram_core

// ### test_flow_through_burst_sram.sv
`timescale 1ns/1ps
// ****************************************
// Self-checking bench
// ****************************************
module test_flow_through_burst_sram;
   logic REF_CLK, RESET_N, OUTPUT_GATE_N, SLEEP_REQUEST, BURST_ORDER;
   logic TEST_CLOCK, TEST_DATA_IN, TEST_MODE_SEL;
   logic [5:0] addr, base, wa, ea;
   logic qual_n, step, we_n, cs1_n, cs2, cs3_n, oe, tds, tms;
   logic [3:0] lanes_n, par_out, wl;
   logic [35:0] wd;
   logic [31:0] dq_out;
   logic [35:0] ref_mem [64];
   logic wr_pend, bwr, bact, pdes, exp_oe, gate_on;
   logic [1:0] cnt, k;
   int bad_count, n_checks, i, j;

   // 125 MHz clock
   initial begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   ftb_sram_core #(.ADDR_W(6)) dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
      .ADDR(addr), .CLOCK_QUALIFIER_N(qual_n), .BURST_STEP_OR_LOAD(step),
      .WRITE_ENABLE_N(we_n), .BYTE_LANE_SELECT_N(lanes_n),
      .CHIP_SELECT_FIRST_N(cs1_n), .CHIP_SELECT_SECOND(cs2),
      .CHIP_SELECT_THIRD_N(cs3_n), .OUTPUT_GATE_N(OUTPUT_GATE_N),
      .SLEEP_REQUEST(SLEEP_REQUEST), .BURST_ORDER(BURST_ORDER),
      .DQ_IN(wd[31:0]), .PARITY_PINS_IN(wd[35:32]), .DQ_OUT(dq_out),
      .PARITY_PINS_OUT(par_out), .DQ_OE(oe), .TEST_CLOCK(TEST_CLOCK),
      .TEST_DATA_IN(TEST_DATA_IN), .TEST_MODE_SEL(TEST_MODE_SEL),
      .TEST_DATA_SAMPLE(tds), .TEST_MODE_SAMPLE(tms));

   ftb_ctl_model ctl (.clk(REF_CLK), .addr(addr), .qual_n(qual_n),
      .step(step), .we_n(we_n), .lanes_n(lanes_n), .cs1_n(cs1_n),
      .cs2(cs2), .cs3_n(cs3_n), .wd(wd));

   // Beat address: only the low two bits move, wrapping in the group
   function automatic logic [5:0] beat(input logic [5:0] b,
      input logic [1:0] s);
      beat = {b[5:2], BURST_ORDER ? b[1:0] ^ s : b[1:0] + s};
   endfunction : beat

   // Word after a write: selected lanes take data and parity bit
   function automatic logic [35:0] merge(input logic [35:0] o,
      input logic [35:0] n, input logic [3:0] ln);
      merge = o;
      for (int m = 0; m < 4; m++) begin
         if (!ln[m]) begin
            merge[8*m +: 8] = n[8*m +: 8];
            merge[32+m] = n[32+m];
         end
      end
   endfunction : merge

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   // One operation; the check looks at the previous one, taken this edge
   task automatic op(input logic [1:0] kind, input logic [5:0] a,
      input logic w_n, input logic [3:0] ln, input logic stl);
      logic [35:0] d;
      d[31:0] = $urandom;
      d[35:32] = 4'($urandom);
      ctl.drive(kind, a, w_n, ln, stl, wr_pend, d);
      @(negedge REF_CLK);
      chk({35'h0, oe}, {35'h0, exp_oe});
      if (exp_oe) chk({par_out, dq_out}, ref_mem[ea]);
      // A stalled edge must leave burst and pending data untouched
      if (stl) ctl.drive(kind, a, w_n, ln, 1'b0, wr_pend, d);
      if (wr_pend) ref_mem[wa] = merge(ref_mem[wa], d, wl);
      if (kind == 2'h1) begin
         base = a;
         bwr = !w_n;
         bact = 1'b1;
         cnt = 2'h0;
      end else if (kind == 2'h2) begin
         cnt = cnt + 2'h1;
      end else begin
         bact = 1'b0;
      end
      ea = beat(base, cnt);
      exp_oe = bact && !bwr && !pdes && gate_on;
      pdes = !bact;
      wr_pend = bact && bwr;
      wa = ea;
      wl = ln;
   endtask : op

   task automatic idle(input int n);
      repeat (n) op(2'h0, 6'h0, 1'b1, 4'hF, 1'b0);
   endtask : idle

   // Reset with the burst order strap; the array keeps its contents
   task automatic start(input logic ord);
      @(posedge REF_CLK);
      BURST_ORDER <= ord;
      RESET_N <= 1'b0;
      repeat (20) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      {pdes, bact, wr_pend, exp_oe} = 4'h8;
      idle(8);
   endtask : start

   // Load then three steps; steps carry junk write enable and selects
   task automatic bursts(input int n, input int m, input logic w_n);
      for (i = 0; i < n; i++) begin
         op(2'h1, 6'(i * m), w_n, 4'h0, 1'b0);
         for (j = 0; j < 3; j++) begin
            op(2'h2, 6'($urandom), !w_n, 4'h0, j == 1);
         end
      end
      idle(1);
   endtask : bursts

   task automatic rand_run(input int n);
      for (i = 0; i < n; i++) begin
         k = 2'($urandom_range(2));
         if (k == 2'h2 && cnt == 2'h3) k = 2'h1;
         op(k, 6'($urandom), 1'($urandom), 4'($urandom),
            $urandom_range(7) == 0);
      end
      idle(1);
   endtask : rand_run

   task automatic scan(input logic di, input logic ms);
      @(posedge REF_CLK);
      TEST_DATA_IN <= di;
      TEST_MODE_SEL <= ms;
      TEST_CLOCK <= 1'b1;
      idle(6);
      chk({34'h0, tds, tms}, {34'h0, di, ms});
      @(posedge REF_CLK);
      TEST_CLOCK <= 1'b0;
      idle(6);
   endtask : scan

   // Hang guard
   initial begin
      repeat (30000) @(posedge REF_CLK);
      bad_count++;
      report_and_stop;
   end

   // Main sequence
   initial begin
      void'($urandom(32'h77502487));
      {OUTPUT_GATE_N, SLEEP_REQUEST, BURST_ORDER, RESET_N} = 4'h0;
      {TEST_CLOCK, TEST_DATA_IN, TEST_MODE_SEL} = 3'h0;
      bad_count = 0;
      n_checks = 0;
      gate_on = 1'b1;
      start(1'b0);
      bursts(16, 4, 1'b0);
      bursts(16, 5, 1'b1);
      $display("test linear bursts done");
      // Byte write, same-edge read, aborted write, read again
      op(2'h1, 6'h2A, 1'b0, 4'h5, 1'b0);
      op(2'h1, 6'h2A, 1'b1, 4'hF, 1'b0);
      op(2'h1, 6'h2A, 1'b0, 4'hF, 1'b0);
      op(2'h1, 6'h2A, 1'b1, 4'hF, 1'b0);
      op(2'h2, 6'h00, 1'b1, 4'hF, 1'b0);
      rand_run(400);
      $display("test random linear done");
      // Output gate closed: reads must not drive
      @(posedge REF_CLK);
      OUTPUT_GATE_N <= 1'b1;
      gate_on = 1'b0;
      idle(5);
      bursts(4, 7, 1'b1);
      @(posedge REF_CLK);
      OUTPUT_GATE_N <= 1'b0;
      idle(5);
      gate_on = 1'b1;
      // Sleep with selects off, then recovery; contents must survive
      @(posedge REF_CLK);
      SLEEP_REQUEST <= 1'b1;
      idle(10);
      @(posedge REF_CLK);
      SLEEP_REQUEST <= 1'b0;
      idle(10);
      bursts(16, 4, 1'b1);
      $display("test gate and sleep done");
      start(1'b1);
      bursts(16, 9, 1'b1);
      rand_run(300);
      $display("test interleaved done");
      scan(1'b1, 1'b0);
      scan(1'b0, 1'b1);
      $display("test scan sampling done");
      report_and_stop;
   end
endmodule : test_flow_through_burst_sram
